// ==== design/bt_params.svh ====
// constants for the registered bus transceiver
`ifndef BT_PARAMS_SVH
`define BT_PARAMS_SVH

`define BT_DATA_W 18
`define BT_ADDR_W 4
`define BT_REG_W 32
`define BT_LOG_DEPTH 8
`define BT_LOG_CNT_W 4

`define BT_REG_CTRL 4'h0
`define BT_REG_A2B_STORE 4'h1
`define BT_REG_B2A_STORE 4'h2
`define BT_REG_LOG 4'h3
`define BT_REG_STATUS 4'h4

`define BT_CTRL_HOLD_A 0
`define BT_CTRL_HOLD_B 1
`define BT_CTRL_RESET 2'h0

`define BT_LOG_VALID_BIT 31
`define BT_STATUS_OVF_BIT 8

`endif

// ==== design/bt_pkg.sv ====
// types shared by the registered bus transceiver
`default_nettype none
`include "bt_params.svh"

package bt_pkg;
    typedef logic [`BT_DATA_W-1:0] bt_word_t;
    typedef logic [`BT_REG_W-1:0] bt_reg_t;
    typedef logic [`BT_ADDR_W-1:0] bt_addr_t;
endpackage : bt_pkg

`default_nettype wire

// ==== design/bt_transceiver.sv ====
// registered 18-bit bidirectional bus transceiver with capture log
// What this block does
// - eighteen data bits each way, own output, latch and clock controls per direction
// - a-to-b latch enable high: b follows a regardless of clock
// - latch enable low, clock steady: stored a value held, a changes ignored
// - latch enable low: a captured on each rising edge of a-to-b clock
// - b port driven only while a-to-b output enable is high
// - a port driven only while active-low b-to-a output enable is low
// - b-to-a path mirrors a-to-b with its own latch enable and clock
// - enabled, latch low, clock resting low: output keeps its earlier value
// - clock resting high keeps value when clock was high as latch enable fell
// - bus hold keeps each input at last driven state when it floats
`default_nettype none
`include "bt_params.svh"

// ****************************************************************
// capture log fifo
// ****************************************************************
module bt_fifo #(
    parameter int W = 18,
    parameter int D = 8,
    parameter int CW = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [CW-1:0] count
);
    localparam int PW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready = (count != CW'(D));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_ready && out_valid;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(D - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(D - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : bt_fifo

// ****************************************************************
// transceiver top
// ****************************************************************
module bt_transceiver
    import bt_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic a_to_b_output_enable,
    input wire logic b_to_a_output_enable_n,
    input wire logic a_to_b_latch_enable,
    input wire logic b_to_a_latch_enable,
    input wire logic a_to_b_capture_clock,
    input wire logic b_to_a_capture_clock,
    input wire logic [`BT_DATA_W-1:0] a_in,
    output logic [`BT_DATA_W-1:0] a_out,
    output logic a_oe,
    input wire logic a_ext_drive,
    input wire logic [`BT_DATA_W-1:0] b_in,
    output logic [`BT_DATA_W-1:0] b_out,
    output logic b_oe,
    input wire logic b_ext_drive,
    output logic capture_log_ready,
    input wire logic [`BT_ADDR_W-1:0] reg_addr,
    input wire logic [`BT_REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`BT_REG_W-1:0] reg_rdata
);
    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta;
    logic rst_q;
    logic rst;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_q <= rst_meta;
        end
    end
    assign rst = !rst_q;

    // ************************************************************
    // control register and bus hold
    // ************************************************************
    logic hold_en_a;
    logic hold_en_b;
    bt_word_t a_last;
    bt_word_t b_last;
    bt_word_t a_eff;
    bt_word_t b_eff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {hold_en_b, hold_en_a} <= `BT_CTRL_RESET;
        end else if (ce && reg_wr && reg_addr == `BT_REG_CTRL) begin
            hold_en_a <= reg_wdata[`BT_CTRL_HOLD_A];
            hold_en_b <= reg_wdata[`BT_CTRL_HOLD_B];
        end
    end

    // a floating input reads back as the last level it was driven to
    assign a_eff = (hold_en_a && !a_ext_drive) ? a_last : a_in;
    assign b_eff = (hold_en_b && !b_ext_drive) ? b_last : b_in;

    always_ff @(posedge mclk) begin
        if (ce) begin
            a_last <= a_eff;
            b_last <= b_eff;
        end
    end

    // ************************************************************
    // storage stages, one per direction
    // ************************************************************
    logic ab_clk_q;
    logic ba_clk_q;
    logic ab_rise;
    logic ba_rise;
    bt_word_t a2b_store;
    bt_word_t b2a_store;
    bt_word_t next_a2b;
    bt_word_t next_b2a;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ab_clk_q <= 1'b1;
            ba_clk_q <= 1'b1;
        end else if (ce) begin
            ab_clk_q <= a_to_b_capture_clock;
            ba_clk_q <= b_to_a_capture_clock;
        end
    end
    // a clock already high at release is not taken as an edge
    assign ab_rise = a_to_b_capture_clock && !ab_clk_q;
    assign ba_rise = b_to_a_capture_clock && !ba_clk_q;

    always_comb begin
        next_a2b = a2b_store;
        if (a_to_b_latch_enable || ab_rise) begin
            next_a2b = a_eff;
        end
        next_b2a = b2a_store;
        if (b_to_a_latch_enable || ba_rise) begin
            next_b2a = b_eff;
        end
    end

    // no reset here: contents are whatever the first load brings
    always_ff @(posedge mclk) begin
        if (ce) begin
            a2b_store <= next_a2b;
            b2a_store <= next_b2a;
        end
    end

    // ************************************************************
    // port drivers
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            b_out <= '0;
            a_out <= '0;
            b_oe <= 1'b0;
            a_oe <= 1'b0;
        end else if (ce) begin
            b_out <= next_a2b;
            a_out <= next_b2a;
            b_oe <= a_to_b_output_enable;
            a_oe <= !b_to_a_output_enable_n;
        end
    end

    // ************************************************************
    // capture log of a-to-b clocked words
    // ************************************************************
    logic log_in_ready;
    logic log_out_valid;
    logic log_pop;
    logic log_push;
    logic overflow;
    bt_word_t log_word;
    logic [`BT_LOG_CNT_W-1:0] log_count;

    assign log_push = !a_to_b_latch_enable && ab_rise;
    assign log_pop = reg_rd && reg_addr == `BT_REG_LOG;

    bt_fifo #(
        .W(`BT_DATA_W),
        .D(`BT_LOG_DEPTH),
        .CW(`BT_LOG_CNT_W)
    ) u_log (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .in_data(a_eff),
        .in_valid(log_push),
        .in_ready(log_in_ready),
        .out_data(log_word),
        .out_valid(log_out_valid),
        .out_ready(log_pop),
        .count(log_count)
    );

    // a capture into a full log is lost; the sticky bit tells software
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            overflow <= 1'b0;
            capture_log_ready <= 1'b0;
        end else if (ce) begin
            capture_log_ready <= log_in_ready;
            if (log_push && !log_in_ready) begin
                overflow <= 1'b1;
            end else if (reg_wr && reg_addr == `BT_REG_STATUS && reg_wdata[`BT_STATUS_OVF_BIT]) begin
                overflow <= 1'b0;
            end
        end
    end

    // ************************************************************
    // register read
    // ************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                unique case (reg_addr)
                    `BT_REG_CTRL: reg_rdata <= {30'h0, hold_en_b, hold_en_a};
                    `BT_REG_A2B_STORE: reg_rdata <= {14'h0, a2b_store};
                    `BT_REG_B2A_STORE: reg_rdata <= {14'h0, b2a_store};
                    `BT_REG_LOG: reg_rdata <= {log_out_valid, 13'h0, log_word};
                    `BT_REG_STATUS: reg_rdata <= {23'h0, overflow, 4'h0, log_count};
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence ab_rest_low_s;
        ce && a_to_b_output_enable && !a_to_b_latch_enable && !a_to_b_capture_clock;
    endsequence

    sequence ab_le_fall_clk_high_s;
        ce && a_to_b_latch_enable && a_to_b_capture_clock
            ##1 ce && !a_to_b_latch_enable && a_to_b_capture_clock;
    endsequence

    ab_transparent_a: assert property (
        ce && a_to_b_latch_enable |=> b_out == $past(a_eff))
        else $error("b does not follow a while latch enable is high");

    ab_hold_a: assert property (
        ce && !a_to_b_latch_enable && !ab_rise |=> a2b_store === $past(a2b_store))
        else $error("a-to-b store changed without edge or latch enable");

    ab_capture_a: assert property (
        ce && !a_to_b_latch_enable && ab_rise |=> a2b_store == $past(a_eff) && b_out == a2b_store)
        else $error("a-to-b rising edge did not capture a");

    b_enable_a: assert property (
        ce |=> b_oe == $past(a_to_b_output_enable))
        else $error("b drive does not track its output enable");

    a_enable_a: assert property (
        ce |=> a_oe != $past(b_to_a_output_enable_n))
        else $error("a drive does not track active-low enable");

    ba_mirror_a: assert property (
        ce && (b_to_a_latch_enable || ba_rise) |=> a_out == $past(b_eff) && b2a_store == a_out)
        else $error("b-to-a path does not mirror a-to-b");

    ab_rest_low_a: assert property (
        ab_rest_low_s ##1 ab_rest_low_s |-> b_out == $past(b_out) && b_oe)
        else $error("output moved while clock rested low");

    ab_rest_high_a: assert property (
        ab_le_fall_clk_high_s ##1 ce && !a_to_b_latch_enable && a_to_b_capture_clock
            |-> b_out == $past(b_out))
        else $error("output moved while clock rested high");

    bus_hold_a: assert property (
        ce && hold_en_a && !a_ext_drive ##1 ce && hold_en_a && !a_ext_drive |-> a_eff == $past(a_eff))
        else $error("floating a input lost its held level");

    log_overflow_a: assert property (
        ce && log_push && !log_in_ready |=> overflow)
        else $error("lost capture did not flag overflow");
endmodule : bt_transceiver

`default_nettype wire

// ==== design/bt_unused.sv ====
// intentionally empty
`default_nettype none
`default_nettype wire

// ==== sim/bt_bus_model.sv ====
// far-side bus logic on the a and b ports
`default_nettype none
`include "bt_params.svh"

// ********
// bus model
// ********
module bt_bus_model
    import bt_pkg::*;
(
    input wire logic mclk,
    input wire logic [`BT_DATA_W-1:0] a_out,
    input wire logic a_oe,
    input wire logic [`BT_DATA_W-1:0] b_out,
    input wire logic b_oe,
    input wire logic [`BT_DATA_W-1:0] a_val,
    input wire logic a_en,
    input wire logic [`BT_DATA_W-1:0] b_val,
    input wire logic b_en,
    output logic [`BT_DATA_W-1:0] a_in,
    output logic a_ext_drive,
    output logic [`BT_DATA_W-1:0] b_in,
    output logic b_ext_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    bt_word_t a_last = '0;
    bt_word_t b_last = '0;
    // an undriven wire shows the inverse of its last level, so a missing hold shows
    assign a_in = a_oe ? a_out : (a_en ? a_val : ~a_last);
    assign b_in = b_oe ? b_out : (b_en ? b_val : ~b_last);
    assign a_ext_drive = a_en;
    assign b_ext_drive = b_en;
    always_ff @(posedge mclk) begin
        if (a_en | a_oe) a_last <= a_in;
        if (b_en | b_oe) b_last <= b_in;
    end
endmodule : bt_bus_model

`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the registered bus transceiver
`default_nettype none
`include "bt_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("Error t=%0t got %0h exp %0h", $time, (g), (e)); end end

// ********
// bench top
// ********
module testbench
    import bt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    int bad_count = 0;
    int samples_checked = 0;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic ab_oe = 1'b0, ba_oen = 1'b1, ab_le = 1'b0, ba_le = 1'b0, ab_ck = 1'b0, ba_ck = 1'b0;
    logic a_en = 1'b1, b_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ce = 1'b1;
    bt_word_t a_val = '0, b_val = '0;
    bt_addr_t reg_addr = '0;
    bt_reg_t reg_wdata = '0;
    bt_word_t a_in, a_out, b_in, b_out;
    logic a_oe, b_oe, a_ext_drive, b_ext_drive, log_rdy;
    bt_reg_t reg_rdata;

    always #10 mclk = ~mclk;

    bt_transceiver i_dut (.mclk, .rstn, .ce, .a_to_b_output_enable(ab_oe),
        .b_to_a_output_enable_n(ba_oen), .a_to_b_latch_enable(ab_le), .b_to_a_latch_enable(ba_le),
        .a_to_b_capture_clock(ab_ck), .b_to_a_capture_clock(ba_ck), .a_in, .a_out, .a_oe, .a_ext_drive,
        .b_in, .b_out, .b_oe, .b_ext_drive, .capture_log_ready(log_rdy), .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata);
    bt_bus_model i_bus (.mclk, .a_out, .a_oe, .b_out, .b_oe, .a_val, .a_en, .b_val, .b_en, .a_in,
        .a_ext_drive, .b_in, .b_ext_drive);

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic rd(input bt_addr_t ad, output bt_reg_t d);
        @(posedge mclk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic wr(input bt_addr_t ad, input bt_reg_t d);
        @(posedge mclk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    // data settles a cycle before the capture clock rises
    task automatic cap(input logic ba, input bt_word_t v);
        @(posedge mclk);
        if (ba) b_val <= v;
        else a_val <= v;
        @(posedge mclk);
        if (ba) ba_ck <= 1'b1;
        else ab_ck <= 1'b1;
        @(posedge mclk);
        if (ba) ba_ck <= 1'b0;
        else ab_ck <= 1'b0;
    endtask : cap
    // nine captures: one more than the log holds
    task automatic t_log();
        bt_reg_t d;
        for (int i = 0; i < 9; i++) cap(1'b0, 18'h30000 + 18'(i));
        cyc(3);
        `CHK(log_rdy, 1'b0);
        rd(`BT_REG_STATUS, d);
        `CHK(d[3:0], 4'h8);
        `CHK(d[`BT_STATUS_OVF_BIT], 1'b1);
        rd(`BT_REG_A2B_STORE, d);
        `CHK(d[17:0], 18'h30008);
        for (int i = 0; i < 8; i++) begin
            rd(`BT_REG_LOG, d);
            `CHK(d[`BT_LOG_VALID_BIT], 1'b1);
            `CHK(d[17:0], 18'h30000 + 18'(i));
        end
        rd(`BT_REG_LOG, d);
        `CHK(d[`BT_LOG_VALID_BIT], 1'b0);
        wr(`BT_REG_STATUS, 32'h00000100);
        rd(`BT_REG_STATUS, d);
        `CHK(d, 32'h00000000);
        rd(4'hF, d);
        `CHK(d, 32'h00000000);
        cyc(3);
        `CHK(log_rdy, 1'b1);
        $display("test log done");
    endtask : t_log
    task automatic t_ab();
        @(posedge mclk);
        b_en <= 1'b0;
        ab_oe <= 1'b1;
        ab_le <= 1'b1;
        ab_ck <= 1'b1;
        a_val <= 18'h2AAAA;
        cyc(3);
        `CHK(b_oe, 1'b1);
        `CHK(b_out, 18'h2AAAA);
        @(posedge mclk);
        ab_le <= 1'b0;
        @(posedge mclk);
        a_val <= 18'h00F0F;
        cyc(3);
        `CHK(b_out, 18'h2AAAA);
        @(posedge mclk);
        ab_ck <= 1'b0;
        cyc(3);
        `CHK(b_out, 18'h2AAAA);
        @(posedge mclk);
        ab_ck <= 1'b1;
        cyc(3);
        `CHK(b_out, 18'h00F0F);
        @(posedge mclk);
        ab_oe <= 1'b0;
        ab_ck <= 1'b0;
        cyc(3);
        `CHK(b_oe, 1'b0);
        $display("test a to b done");
    endtask : t_ab
    task automatic t_ba();
        @(posedge mclk);
        a_en <= 1'b0;
        b_en <= 1'b1;
        b_val <= 18'h01234;
        ba_le <= 1'b1;
        ba_oen <= 1'b0;
        cyc(3);
        `CHK(a_oe, 1'b1);
        `CHK(a_out, 18'h01234);
        @(posedge mclk);
        ba_le <= 1'b0;
        @(posedge mclk);
        b_val <= 18'h3C3C3;
        cyc(3);
        `CHK(a_out, 18'h01234);
        cap(1'b1, 18'h2F0F1);
        cyc(3);
        `CHK(a_out, 18'h2F0F1);
        @(posedge mclk);
        ba_oen <= 1'b1;
        cyc(3);
        `CHK(a_oe, 1'b0);
        $display("test b to a done");
    endtask : t_ba
    task automatic t_hold();
        bt_reg_t d;
        @(posedge mclk);
        a_en <= 1'b1;
        a_val <= 18'h0A5A5;
        b_en <= 1'b0;
        ab_le <= 1'b1;
        ab_oe <= 1'b1;
        wr(`BT_REG_CTRL, 32'h00000001);
        cyc(3);
        `CHK(b_out, 18'h0A5A5);
        @(posedge mclk);
        a_en <= 1'b0;
        cyc(3);
        `CHK(b_out, 18'h0A5A5);
        rd(`BT_REG_A2B_STORE, d);
        `CHK(d[17:0], 18'h0A5A5);
        rd(`BT_REG_CTRL, d);
        `CHK(d, 32'h00000001);
        wr(`BT_REG_CTRL, 32'h00000000);
        cyc(3);
        `CHK(b_out, 18'h35A5A);
        @(posedge mclk);
        ab_oe <= 1'b0;
        b_en <= 1'b1;
        b_val <= 18'h1B1B1;
        ba_le <= 1'b1;
        wr(`BT_REG_CTRL, 32'h00000002);
        rd(`BT_REG_CTRL, d);
        `CHK(d, 32'h00000002);
        @(posedge mclk);
        b_en <= 1'b0;
        cyc(3);
        `CHK(a_out, 18'h1B1B1);
        wr(`BT_REG_CTRL, 32'h00000000);
        cyc(3);
        `CHK(a_out, 18'h24E4E);
        $display("test bus hold done");
    endtask : t_hold
    // a low clock enable freezes the data path and the enables
    task automatic t_ce();
        @(posedge mclk);
        a_en <= 1'b1;
        a_val <= 18'h12345;
        ab_le <= 1'b1;
        ab_oe <= 1'b1;
        cyc(3);
        `CHK(b_out, 18'h12345);
        @(posedge mclk);
        ce <= 1'b0;
        ab_oe <= 1'b0;
        a_val <= 18'h0BEEF;
        cyc(3);
        `CHK(b_out, 18'h12345);
        `CHK(b_oe, 1'b1);
        @(posedge mclk);
        ce <= 1'b1;
        cyc(3);
        `CHK(b_out, 18'h0BEEF);
        `CHK(b_oe, 1'b0);
        $display("test clock enable done");
    endtask : t_ce
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    initial begin
        #200us;
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        cyc(3);
        `CHK(b_oe, 1'b0);
        t_log();
        t_ab();
        t_ba();
        t_hold();
        t_ce();
        finish_test();
    end
endmodule : testbench

`default_nettype wire
